// ===== core/cfg_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "vcb_regs.svh"
module cfg_decode #(
    parameter bit BOOT_DDR8 = 1'b0
) (
    input wire logic [7:0] io_i,
    input wire logic [7:0] dummy_i,
    input wire logic [7:0] drive_i,
    input wire logic [7:0] abytes_i,
    input wire logic [7:0] xip_i,
    input wire logic [7:0] wrap_i,
    input wire logic [7:0] pat_i,
    input wire logic [7:0] integ_i,
    output vcb_pkg::cfg_s cfg_o
);
    // Reserved codes fall back to the default setting
    function automatic logic [1:0] quad(input logic [7:0] c);
        case (c)
            `CODE_FE: quad = 2'b01;
            `CODE_FD: quad = 2'b10;
            `CODE_FC: quad = 2'b11;
            default: quad = 2'b00;
        endcase
    endfunction
    always_comb begin
        cfg_o = '0;
        case (io_i) // [R17]
            `CODE_SPI_NOSTB: cfg_o.proto = vcb_pkg::PROTO_SPI;
            `CODE_ODDR: cfg_o.proto = vcb_pkg::PROTO_ODDR_STB;
            `CODE_ODDR_NOSTB: cfg_o.proto = vcb_pkg::PROTO_ODDR;
            default: cfg_o.proto = vcb_pkg::PROTO_SPI_STB;
        endcase
        if (BOOT_DDR8) begin
            cfg_o.proto = vcb_pkg::PROTO_ODDR_STB; // [R18]
        end
        if (dummy_i == 8'h00 || dummy_i > `DUMMY_MAX) begin
            cfg_o.dummy_dflt = 1'b1; // [R15]
        end else begin
            cfg_o.dummy = dummy_i[4:0]; // [R14]
        end
        cfg_o.wrap = vcb_pkg::wrap_e'(quad(wrap_i)); // [R10]
        cfg_o.drive = vcb_pkg::drive_e'(quad(drive_i)); // [R13]
        cfg_o.xip_en = (xip_i == `CODE_FE); // [R11]
        cfg_o.addr4 = (abytes_i == `CODE_FE); // [R12]
        cfg_o.chunk_bytes = 8'(8'h10 << (2'h3 - integ_i[5:4])); // [R2]
        cfg_o.parity_en = ~integ_i[`BIT_PARITY_N]; // [R3]
        cfg_o.err_sel_det = integ_i[`BIT_ERR_SEL]; // [R4]
        cfg_o.err_pin_en = ~integ_i[`BIT_ERR_PIN_N]; // [R7]
        cfg_o.ecc_en = ~integ_i[`BIT_ECC_N]; // [R8]
        cfg_o.pattern = pat_i; // [R9]
        cfg_o.pattern_dq3 = integ_i[`BIT_SSO] ? pat_i : ~pat_i; // [R1]
    end
endmodule
`default_nettype wire

// ===== core/link_sync.sv
`timescale 1ns/1ps
`default_nettype none
module link_sync #(
    parameter int W = 31
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    // Only the second stage is visible outside
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d_i;
            q_ff <= meta_ff;
        end
    end
    assign q_o = q_ff;
endmodule
`default_nettype wire

// ===== core/vcb_pkg.sv
`default_nettype none
package vcb_pkg;
    typedef enum logic [1:0] {
        PROTO_SPI_STB = 2'b00,
        PROTO_SPI = 2'b01,
        PROTO_ODDR_STB = 2'b10,
        PROTO_ODDR = 2'b11
    } proto_e;
    typedef enum logic [1:0] {
        WRAP_NONE = 2'b00, WRAP_64 = 2'b01, WRAP_32 = 2'b10, WRAP_16 = 2'b11
    } wrap_e;
    typedef enum logic [1:0] {
        DRV_50 = 2'b00, DRV_35 = 2'b01, DRV_25 = 2'b10, DRV_18 = 2'b11
    } drive_e;
    typedef struct packed {
        proto_e proto;
        logic [4:0] dummy;
        logic dummy_dflt;
        wrap_e wrap;
        logic xip_en;
        logic addr4;
        drive_e drive;
        logic [7:0] chunk_bytes;
        logic parity_en;
        logic err_sel_det;
        logic err_pin_en;
        logic ecc_en;
        logic [7:0] pattern;
        logic [7:0] pattern_dq3;
    } cfg_s;
    typedef struct packed {
        logic sclk;
        logic corr;
        logic det;
        logic [27:0] addr;
    } link_s;
endpackage
`default_nettype wire

// ===== core/vcb_regs.svh
`ifndef VCB_REGS_SVH
`define VCB_REGS_SVH
// Notes on behaviour
// R1 - Bit 6 low inverts training lane three
// R2 - Bits 5:4 pick check chunk size
// R3 - Bit 3 low enables octal parity checks
// R4 - Bit 2 picks which ECC event drives error
// R5 - Same bit picks event class for address
// R6 - Event selection acts only with ECC on
// R7 - Bit 1 low turns error pin on
// R8 - Bit 0 low turns ECC on
// R9 - Training pattern byte, resets to 55h
// R10 - Wrap byte: continuous, 64, 32, 16
// R11 - XIP enabled only by code FEh
// R12 - Address bytes: FFh three, FEh four
// R13 - Drive code selects 50 to 18 ohm
// R14 - Dummy codes 01h-1Eh give cycle counts
// R15 - Dummy code 00h behaves like 1Fh
// R16 - Host programs enough dummy cycles
// R17 - Protocol byte picks SPI or octal DDR
// R18 - Octal boot parts stay octal DDR strobed
// R19 - Correction counter saturates at fifteen
// R20 - First selected event address is recorded
// R21 - All bytes return to defaults on reset

// ==========================================
// Register indices, byte address is four times
`define IDX_IO_MODE 5'h00
`define IDX_DUMMY 5'h01
`define IDX_DRIVE 5'h03
`define IDX_ADDR_BYTES 5'h05
`define IDX_XIP 5'h06
`define IDX_WRAP 5'h07
`define IDX_PATTERN 5'h0a
`define IDX_INTEGRITY 5'h0b
`define IDX_STATUS 5'h0c
`define IDX_FCA0 5'h0d
`define IDX_FCA1 5'h0e
`define IDX_FCA2 5'h0f
`define IDX_FCA3 5'h10

// ==========================================
// Reset values
`define RST_IO_MODE 8'hff
`define RST_DUMMY 8'h1f
`define RST_DRIVE 8'hff
`define RST_ADDR_BYTES 8'hff
`define RST_XIP 8'hff
`define RST_WRAP 8'hff
`define RST_PATTERN 8'h55
`define RST_INTEGRITY 8'h7f

// ==========================================
// Field positions and codes
`define BIT_SSO 6
`define BIT_PARITY_N 3
`define BIT_ERR_SEL 2
`define BIT_ERR_PIN_N 1
`define BIT_ECC_N 0
`define CODE_FF 8'hff
`define CODE_FE 8'hfe
`define CODE_FD 8'hfd
`define CODE_FC 8'hfc
`define CODE_SPI_NOSTB 8'hdf
`define CODE_ODDR 8'he7
`define CODE_ODDR_NOSTB 8'hc7
`define DUMMY_MAX 8'h1e
`define CNT_MAX 4'hf
`endif

// ===== core/vcb_top.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "vcb_regs.svh"
module vcb_top #(
    parameter bit BOOT_DDR8 = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic link_clk_i,
    input wire logic corr_event_i,
    input wire logic det_event_i,
    input wire logic [27:0] event_addr_i,
    output vcb_pkg::cfg_s cfg_o,
    output logic err_pin_o,
    output logic err_pin_oe_n_o
);
    // ==========================================
    // Register storage
    logic [7:0] io_ff;
    logic [7:0] dummy_ff;
    logic [7:0] drive_ff;
    logic [7:0] abytes_ff;
    logic [7:0] xip_ff;
    logic [7:0] wrap_ff;
    logic [7:0] pat_ff;
    logic [7:0] integ_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic det_seen_ff;
    logic [27:0] fca_ff;
    logic fca_valid_ff;
    logic err_flag_ff;
    logic err_drive_ff;
    logic sclk_prev_ff;
    logic [31:0] prdata_ff;
    logic pslverr_ff;
    vcb_pkg::cfg_s cfg_ff;
    vcb_pkg::cfg_s nxt_cfg;
    vcb_pkg::link_s lk;

    // ==========================================
    // Bus decode
    logic [4:0] idx;
    logic mapped;
    logic setup;
    logic access;
    logic wr;
    logic clr;

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a[1:0] == 2'b00) && !a[7] && (a[6:2] <= `IDX_FCA3);
    endfunction

    assign idx = paddr_i[6:2];
    assign mapped = is_mapped(paddr_i);
    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i;
    // Zero wait states; data was prepared in setup
    assign pready_o = 1'b1;
    assign wr = access && pwrite_i && mapped;
    // Writing the status word clears the event records
    assign clr = wr && (idx == `IDX_STATUS);

    // ==========================================
    // Configuration writes
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            io_ff <= `RST_IO_MODE; // [R21]
            dummy_ff <= `RST_DUMMY;
            drive_ff <= `RST_DRIVE;
            abytes_ff <= `RST_ADDR_BYTES;
            xip_ff <= `RST_XIP;
            wrap_ff <= `RST_WRAP;
            pat_ff <= `RST_PATTERN;
            integ_ff <= `RST_INTEGRITY;
        end else if (wr) begin
            case (idx)
                `IDX_IO_MODE: begin
                    io_ff <= pwdata_i[7:0];
                end
                `IDX_DUMMY: begin
                    dummy_ff <= pwdata_i[7:0];
                end
                `IDX_DRIVE: begin
                    drive_ff <= pwdata_i[7:0];
                end
                `IDX_ADDR_BYTES: begin
                    abytes_ff <= pwdata_i[7:0];
                end
                `IDX_XIP: begin
                    xip_ff <= pwdata_i[7:0];
                end
                `IDX_WRAP: begin
                    wrap_ff <= pwdata_i[7:0];
                end
                `IDX_PATTERN: begin
                    pat_ff <= pwdata_i[7:0];
                end
                `IDX_INTEGRITY: begin
                    integ_ff <= {1'b0, pwdata_i[6:0]};
                end
                default: begin
                end
            endcase
        end
    end

    // ==========================================
    // Decoded configuration
    cfg_decode #(
        .BOOT_DDR8(BOOT_DDR8)
    ) u_decode (
        .io_i(io_ff),
        .dummy_i(dummy_ff),
        .drive_i(drive_ff),
        .abytes_i(abytes_ff),
        .xip_i(xip_ff),
        .wrap_i(wrap_ff),
        .pat_i(pat_ff),
        .integ_i(integ_ff),
        .cfg_o(nxt_cfg)
    );

    // One cycle behind the bytes, so reset must cover two edges
    always_ff @(posedge clk_i) begin
        cfg_ff <= nxt_cfg;
    end
    assign cfg_o = cfg_ff;

    // ==========================================
    // Link side sampling
    link_sync #(
        .W(31)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .d_i({link_clk_i, corr_event_i, det_event_i, event_addr_i}),
        .q_o(lk)
    );

    logic sclk_rise;
    logic ecc_on;
    logic sel_evt;
    logic corr_hit;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_prev_ff <= lk.sclk;
        end
    end

    // Events are only sampled on a rising link edge
    assign sclk_rise = lk.sclk && !sclk_prev_ff;
    assign ecc_on = ~integ_ff[`BIT_ECC_N]; // [R8]
    assign sel_evt = integ_ff[`BIT_ERR_SEL] ? lk.det : lk.corr; // [R4] [R5]
    assign corr_hit = sclk_rise && ecc_on && lk.corr;

    // ==========================================
    // Correction counter
    always_comb begin
        nxt_cnt = clr ? 4'h0 : cnt_ff;
        // A clear and an increment in the same cycle leave the count at one
        if (corr_hit && cnt_ff != `CNT_MAX) begin
            nxt_cnt = clr ? 4'h1 : 4'(cnt_ff + 4'h1); // [R19]
        end else if (corr_hit && clr) begin
            nxt_cnt = 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            det_seen_ff <= 1'b0;
        end else if (sclk_rise && ecc_on && lk.det) begin
            det_seen_ff <= 1'b1;
        end else if (clr) begin
            det_seen_ff <= 1'b0;
        end
    end

    // ==========================================
    // First failing chunk address
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            fca_ff <= 28'h0;
            fca_valid_ff <= 1'b0;
        end else if (sclk_rise && ecc_on && sel_evt && (!fca_valid_ff || clr)) begin
            fca_ff <= lk.addr; // [R20] [R6]
            fca_valid_ff <= 1'b1;
        end else if (clr) begin
            fca_ff <= 28'h0;
            fca_valid_ff <= 1'b0;
        end
    end

    // ==========================================
    // Error pin, open drain, pulled low when driven
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            err_flag_ff <= 1'b0;
        end else if (sclk_rise && ecc_on && sel_evt) begin
            err_flag_ff <= 1'b1; // [R6]
        end else if (clr) begin
            err_flag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            err_drive_ff <= 1'b0;
        end else begin
            err_drive_ff <= err_flag_ff && !integ_ff[`BIT_ERR_PIN_N]; // [R7]
        end
    end

    assign err_pin_o = 1'b0;
    assign err_pin_oe_n_o = !err_drive_ff;

    // ==========================================
    // Read data, captured during setup
    function automatic logic [7:0] rd_byte(input logic [4:0] i);
        case (i)
            `IDX_IO_MODE: rd_byte = io_ff;
            `IDX_DUMMY: rd_byte = dummy_ff;
            `IDX_DRIVE: rd_byte = drive_ff;
            `IDX_ADDR_BYTES: rd_byte = abytes_ff;
            `IDX_XIP: rd_byte = xip_ff;
            `IDX_WRAP: rd_byte = wrap_ff;
            `IDX_PATTERN: rd_byte = pat_ff;
            `IDX_INTEGRITY: rd_byte = integ_ff;
            `IDX_STATUS: rd_byte = {1'b0, cnt_ff, det_seen_ff, 2'b00};
            `IDX_FCA0: rd_byte = {fca_ff[3:0], 4'h0};
            `IDX_FCA1: rd_byte = fca_ff[11:4];
            `IDX_FCA2: rd_byte = fca_ff[19:12];
            `IDX_FCA3: rd_byte = fca_ff[27:20];
            default: rd_byte = 8'h00;
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            prdata_ff <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff <= mapped ? {24'h0, rd_byte(idx)} : 32'h0;
            pslverr_ff <= !mapped;
        end
    end

    assign prdata_o = prdata_ff;
    assign pslverr_o = pslverr_ff && access;

    // ==========================================
    // Checks
    AST_CNT_SAT: assert property ( // [R19]
        @(posedge clk_i) disable iff (!rst_n_i)
        (cnt_ff == 4'hf && !clr) |=> (cnt_ff == 4'hf))
        else $error("counter left saturation");

    AST_CNT_INC: assert property ( // [R19]
        @(posedge clk_i) disable iff (!rst_n_i)
        (corr_hit && cnt_ff != 4'hf && !clr) |=> (cnt_ff == $past(cnt_ff) + 4'h1))
        else $error("counter missed a correction");

    AST_ECC_OFF: assert property ( // [R6]
        @(posedge clk_i) disable iff (!rst_n_i)
        (!ecc_on && !clr) |=> ($stable(cnt_ff) && $stable(fca_ff) && $stable(err_flag_ff)))
        else $error("event recorded with ECC off");

    AST_FCA_FIRST: assert property ( // [R20]
        @(posedge clk_i) disable iff (!rst_n_i)
        (fca_valid_ff && !clr) |=> $stable(fca_ff))
        else $error("first failing address overwritten");

    AST_FCA_SEL: assert property ( // [R5]
        @(posedge clk_i) disable iff (!rst_n_i)
        (sclk_rise && ecc_on && !fca_valid_ff && !clr
            && (integ_ff[2] ? lk.det : lk.corr)) |=> (fca_ff == $past(lk.addr)))
        else $error("selected event address not captured");

    AST_ERR_PIN: assert property ( // [R7]
        @(posedge clk_i) disable iff (!rst_n_i)
        !err_pin_oe_n_o |-> ($past(err_flag_ff) && !$past(integ_ff[1])))
        else $error("error pin driven while disabled");

    AST_DEFAULTS: assert property ( // [R21]
        @(posedge clk_i)
        !rst_n_i |=> (io_ff == 8'hff && dummy_ff == 8'h1f && pat_ff == 8'h55
            && integ_ff == 8'h7f && wrap_ff == 8'hff && xip_ff == 8'hff))
        else $error("byte not at default after reset");

    AST_DQ3: assert property ( // [R1]
        @(posedge clk_i) disable iff (!rst_n_i)
        ##1 (cfg_o.pattern_dq3 == ($past(integ_ff[6]) ? cfg_o.pattern : ~cfg_o.pattern)))
        else $error("lane three pattern wrong");

    AST_DUMMY_ZERO: assert property ( // [R15]
        @(posedge clk_i) disable iff (!rst_n_i)
        (dummy_ff == 8'h00) |=> (cfg_o.dummy_dflt && cfg_o.dummy == 5'h00))
        else $error("zero dummy code not treated as default");

    AST_CHUNK: assert property ( // [R2]
        @(posedge clk_i) disable iff (!rst_n_i)
        (integ_ff[5:4] == 2'b11) |=> (cfg_o.chunk_bytes == 8'h10))
        else $error("default chunk size not sixteen bytes");

    AST_BOOT: assert property ( // [R18]
        @(posedge clk_i) disable iff (!rst_n_i)
        BOOT_DDR8 |=> (cfg_o.proto == vcb_pkg::PROTO_ODDR_STB))
        else $error("octal boot part left octal DDR");

    AST_XIP: assert property ( // [R11]
        @(posedge clk_i) disable iff (!rst_n_i)
        (xip_ff != 8'hfe) |=> !cfg_o.xip_en)
        else $error("XIP enabled by wrong code");

    AST_PIN_ON: assert property ( // [R7]
        @(posedge clk_i) disable iff (!rst_n_i)
        (err_flag_ff && !integ_ff[`BIT_ERR_PIN_N]) |=> !err_pin_oe_n_o)
        else $error("error pin not driven while enabled");

    AST_REC_CLR: assert property ( // [R20]
        @(posedge clk_i) disable iff (!rst_n_i)
        (clr && !(sclk_rise && ecc_on && sel_evt))
            |=> (!fca_valid_ff && fca_ff == 28'h0 && !err_flag_ff))
        else $error("status write did not clear the records");

    AST_PARITY: assert property ( // [R3]
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (cfg_o.parity_en == !$past(integ_ff[`BIT_PARITY_N])))
        else $error("parity enable does not follow its bit");

    AST_ECC_EN: assert property ( // [R8]
        @(posedge clk_i) disable iff (!rst_n_i)
        1'b1 |=> (cfg_o.ecc_en == !$past(integ_ff[`BIT_ECC_N])))
        else $error("correction enable does not follow its bit");
endmodule
`default_nettype wire

// ===== verif/link_event_model.sv
`timescale 1ns/1ps
`default_nettype none
module link_event_model (
    output logic link_clk_o,
    output logic corr_o,
    output logic det_o,
    output logic [27:0] addr_o
);
    // ====
    // Event source, link clock still between frames
    initial begin
        link_clk_o = 1'b0;
        corr_o = 1'b0;
        det_o = 1'b0;
        addr_o = 28'h0;
    end

    task automatic send(input logic c, input logic d, input logic [27:0] a);
        // Keep every pin change off the system clock edge
        #2;
        corr_o = c;
        det_o = d;
        addr_o = a;
        #32 link_clk_o = 1'b1;
        #32 link_clk_o = 1'b0;
        // Released lines flip so stale values never look valid
        corr_o = ~c;
        det_o = ~d;
        addr_o = ~a;
    endtask
endmodule
`default_nettype wire

// ===== verif/volatile_config_register_bank_bench.sv
`timescale 1ns/1ps
`default_nettype none
module volatile_config_register_bank_bench;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o, pslverr_o, link_clk, corr, det, err_pin_o, err_pin_oe_n_o;
    logic [27:0] ev_addr;
    vcb_pkg::cfg_s cfg_o, cfg_b8;
    int fail_count = 0;
    int n_compared = 0;
    int seed = 62391;
    logic [31:0] rd;
    logic e;
    logic [7:0] sh [12] = '{8'hff, 8'h1f, 0, 8'hff, 0, 8'hff, 8'hff, 8'hff, 0, 0, 8'h55, 8'h7f};
    logic [7:0] codes [13] = '{8'hff, 8'hfe, 8'hfd, 8'hfc, 8'hdf, 8'he7, 8'hc7,
        8'h00, 8'h01, 8'h1e, 8'h1f, 8'h20, 8'h10};
    logic [4:0] regl [6] = '{5'h00, 5'h01, 5'h03, 5'h05, 5'h06, 5'h07};
    logic [7:0] bad [4] = '{8'h81, 8'h2e, 8'h44, 8'hfc};

    vcb_top #(.BOOT_DDR8(1'b0)) i_vcb_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .link_clk_i(link_clk), .corr_event_i(corr), .det_event_i(det),
        .event_addr_i(ev_addr), .cfg_o(cfg_o), .err_pin_o(err_pin_o),
        .err_pin_oe_n_o(err_pin_oe_n_o));
    vcb_top #(.BOOT_DDR8(1'b1)) i_vcb_top_boot8 (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(), .pready_o(), .pslverr_o(), .link_clk_i(link_clk),
        .corr_event_i(corr), .det_event_i(det), .event_addr_i(ev_addr), .cfg_o(cfg_b8),
        .err_pin_o(), .err_pin_oe_n_o());
    link_event_model i_link_event_model (.link_clk_o(link_clk), .corr_o(corr), .det_o(det),
        .addr_o(ev_addr));

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    // ====
    // Checking and bus tasks
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_word(input string nm, input logic [63:0] x, input logic [63:0] g);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic x, input logic g);
        n_compared++;
        if (g !== x) begin
            fail_count++;
            $display("ERROR %s expected %b seen %b", nm, x, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] r, output logic er);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready_o !== 1'b1 && n < 50);
        chk_pin("pready", 1'b1, pready_o);
        r = prdata_o;
        er = pslverr_o;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input string nm, input logic [4:0] i, input logic [31:0] x);
        apb(1'b0, {1'b0, i, 2'b00}, 32'h0, rd, e);
        chk_word(nm, x, rd);
        chk_pin("pslverr", 1'b0, e);
    endtask

    function automatic logic [1:0] sel4(input logic [7:0] c);
        case (c)
            8'hfe: return 2'd1;
            8'hfd: return 2'd2;
            8'hfc: return 2'd3;
            default: return 2'd0;
        endcase
    endfunction

    function automatic logic [1:0] proto_of(input logic [7:0] c);
        case (c)
            8'hdf: return 2'd1;
            8'he7: return 2'd2;
            8'hc7: return 2'd3;
            default: return 2'd0;
        endcase
    endfunction

    function automatic vcb_pkg::cfg_s exp_cfg();
        vcb_pkg::cfg_s c;
        c.proto = vcb_pkg::proto_e'(proto_of(sh[0]));
        c.dummy_dflt = sh[1] == 8'h00 || sh[1] > 8'h1e;
        c.dummy = c.dummy_dflt ? 5'h0 : sh[1][4:0];
        c.wrap = vcb_pkg::wrap_e'(sel4(sh[7]));
        c.xip_en = sh[6] == 8'hfe;
        c.addr4 = sh[5] == 8'hfe;
        c.drive = vcb_pkg::drive_e'(sel4(sh[3]));
        c.chunk_bytes = 8'h80 >> sh[11][5:4];
        c.parity_en = !sh[11][3];
        c.err_sel_det = sh[11][2];
        c.err_pin_en = !sh[11][1];
        c.ecc_en = !sh[11][0];
        c.pattern = sh[10];
        c.pattern_dq3 = sh[11][6] ? sh[10] : ~sh[10];
        return c;
    endfunction

    task automatic wrc(input logic [4:0] i, input logic [7:0] d);
        apb(1'b1, {1'b0, i, 2'b00}, {24'h0, d}, rd, e);
        sh[i] = (i == 5'h0b) ? {1'b0, d[6:0]} : d;
        rdc("readback", i, {24'h0, sh[i]});
        repeat (2) @(posedge clk_i);
        chk_word("cfg", exp_cfg(), cfg_o);
    endtask

    task automatic ev(input logic c, input logic d, input logic [27:0] a);
        i_link_event_model.send(c, d, a);
        repeat (8) @(posedge clk_i);
    endtask

    task automatic chk_rec(input logic [3:0] cnt, input logic ds, input logic [27:0] a);
        rdc("status", 5'h0c, {24'h0, 1'b0, cnt, ds, 2'b00});
        rdc("fca0", 5'h0d, {24'h0, a[3:0], 4'h0});
        rdc("fca1", 5'h0e, {24'h0, a[11:4]});
        rdc("fca2", 5'h0f, {24'h0, a[19:12]});
        rdc("fca3", 5'h10, {24'h0, a[27:20]});
    endtask

    // ====
    // Main sequence
    initial begin
        int k;
        int j;
        logic [27:0] a;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 12; k++) begin
            rdc("reset value", 5'(k), {24'h0, sh[k]});
        end
        chk_word("cfg reset", exp_cfg(), cfg_o);
        for (k = 0; k < 6; k++) begin
            for (j = 0; j < 13; j++) begin
                codes[12] = 8'($random(seed));
                wrc(regl[k], codes[j]);
                chk_word("boot8 proto", vcb_pkg::PROTO_ODDR_STB, cfg_b8.proto);
            end
        end
        // Host leaves the per-command default, always long enough
        wrc(5'h01, 8'h1f);
        wrc(5'h0b, 8'h00);
        for (k = 0; k < 10; k++) begin
            wrc(5'h0a, 8'($random(seed)));
            wrc(5'h0b, 8'($random(seed)));
        end
        for (k = 0; k < 4; k++) begin
            apb(1'b1, bad[k], 32'($random(seed)), rd, e);
            chk_pin("write pslverr", 1'b1, e);
            apb(1'b0, bad[k], 32'h0, rd, e);
            chk_pin("read pslverr", 1'b1, e);
            chk_word("bad read", 64'h0, rd);
        end
        apb(1'b1, 8'h34, 32'hff, rd, e);
        repeat (2) @(posedge clk_i);
        chk_word("cfg kept", exp_cfg(), cfg_o);
        wrc(5'h0b, 8'h7f);
        ev(1'b1, 1'b0, 28'h1234567);
        ev(1'b0, 1'b1, 28'h7654321);
        chk_rec(4'h0, 1'b0, 28'h0);
        chk_pin("pin off", 1'b1, err_pin_oe_n_o);
        wrc(5'h0b, 8'h7c);
        for (k = 0; k < 17; k++) begin
            ev(1'b1, 1'b0, 28'($random(seed)));
            rdc("count", 5'h0c, {24'h0, 1'b0, 4'((k < 15) ? k + 1 : 15), 3'b000});
            chk_pin("corr no pin", 1'b1, err_pin_oe_n_o);
        end
        a = 28'($random(seed));
        ev(1'b0, 1'b1, a);
        ev(1'b0, 1'b1, ~a);
        chk_rec(4'hf, 1'b1, a);
        chk_pin("det pin", 1'b0, err_pin_oe_n_o);
        chk_pin("pin data", 1'b0, err_pin_o);
        wrc(5'h0b, 8'h7e);
        chk_pin("pin gated", 1'b1, err_pin_oe_n_o);
        apb(1'b1, 8'h30, 32'h0, rd, e);
        wrc(5'h0b, 8'h78);
        ev(1'b0, 1'b1, a);
        rdc("fca det unsel", 5'h0e, 32'h0);
        chk_pin("det unsel pin", 1'b1, err_pin_oe_n_o);
        apb(1'b1, 8'h30, 32'h0, rd, e);
        ev(1'b1, 1'b0, ~a);
        chk_rec(4'h1, 1'b0, ~a);
        chk_pin("corr pin", 1'b0, err_pin_oe_n_o);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        sh = '{8'hff, 8'h1f, 0, 8'hff, 0, 8'hff, 8'hff, 8'hff, 0, 0, 8'h55, 8'h7f};
        chk_pin("reset pin", 1'b1, err_pin_oe_n_o);
        for (k = 0; k < 12; k++) begin
            rdc("reset again", 5'(k), {24'h0, sh[k]});
        end
        chk_rec(4'h0, 1'b0, 28'h0);
        chk_word("cfg reset again", exp_cfg(), cfg_o);
        give_verdict();
    end

    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
